//--- rtl/chan_power_pkg.sv
package chan_power_pkg;

  // ----------------------------------------------------------------
  // register offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] CHANNEL_ENABLE_ADDR       = 8'h76;
  localparam logic [7:0] DYNAMIC_POWER_CONFIG_ADDR = 8'h77;
  localparam logic [7:0] POWER_CONTROL_ADDR        = 8'h78;
  localparam logic [7:0] CHANNEL_POWER_STATUS_ADDR = 8'h79;

  // ----------------------------------------------------------------
  // reset values and writable masks
  // ----------------------------------------------------------------
  localparam logic [7:0] CHANNEL_ENABLE_RESET       = 8'hcc;
  localparam logic [7:0] DYNAMIC_POWER_CONFIG_RESET = 8'h00;
  localparam logic [7:0] POWER_CONTROL_RESET        = 8'h00;
  localparam logic [7:0] CHANNEL_POWER_STATUS_RESET = 8'h00;
  localparam logic [7:0] CHANNEL_ENABLE_WMASK       = 8'hff;
  localparam logic [7:0] DYNAMIC_POWER_CONFIG_WMASK = 8'hf8;
  localparam logic [7:0] POWER_CONTROL_WMASK        = 8'hee;

  // ----------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------
  localparam int INPUT_ENABLE_LSB          = 4; // bit 7 is channel one
  localparam int DYNAMIC_SWITCH_BIT        = 7;
  localparam int DYNAMIC_RANGE_BIT         = 6;
  localparam int DYNAMIC_SEP_CLOCK_BIT     = 3;
  localparam int CONVERTER_GLOBAL_BIT      = 7;
  localparam int MIC_SUPPLY_BIT            = 5;
  localparam int ULTRASOUND_DETECT_BIT     = 3;
  localparam int VOICE_DETECT_BIT          = 2;
  localparam int POWERED_STATUS_LSB        = 4;

  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam int CLK_PERIOD_NS      = 25;
  localparam int POWER_UP_TIME_NS   = 1000;
  localparam int POWER_DOWN_TIME_NS = 500;
  localparam int POWER_UP_CYC_INT   = (POWER_UP_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int POWER_DOWN_CYC_INT = (POWER_DOWN_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [7:0] POWER_UP_CYCLES   = 8'(POWER_UP_CYC_INT);
  localparam logic [7:0] POWER_DOWN_CYCLES = 8'(POWER_DOWN_CYC_INT);
  localparam logic [7:0] COUNT_RESET       = 8'h00;

  // ----------------------------------------------------------------
  // channel sequencer states
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    CH_OFF      = 2'b00,
    CH_RAMP_UP  = 2'b01,
    CH_ON       = 2'b10,
    CH_RAMP_DN  = 2'b11
  } chan_state_t;

endpackage : chan_power_pkg

//--- rtl/chan_power_seq.sv
`timescale 1ns/100ps
module chan_power_seq (
  input  wire logic sys_clk,
  input  wire logic rst,
  input  wire logic target_on,
  input  wire logic allow_change,
  output logic      supply_on,
  output logic      powered
);
  import chan_power_pkg::*;

  chan_state_t state_q;
  chan_state_t state_d;
  logic [7:0]  count_q;
  logic [7:0]  count_d;
  logic        count_done;
  logic        go_up;
  logic        go_down;

  // ----------------------------------------------------------------
  // decisions
  // ----------------------------------------------------------------
  assign count_done = (count_q == 8'h01);
  assign go_up      = target_on & allow_change;
  assign go_down    = ~target_on & allow_change;

  // next state: a ramp always runs to its end before turning round
  always_comb begin
    state_d = state_q;
    count_d = count_q;
    unique case (state_q)
      CH_OFF: begin
        if (go_up) begin
          state_d = CH_RAMP_UP;
          count_d = POWER_UP_CYCLES;
        end
      end
      CH_RAMP_UP: begin
        count_d = count_q - 8'h01;
        if (count_done) begin
          state_d = CH_ON;
        end
      end
      CH_ON: begin
        if (go_down) begin
          state_d = CH_RAMP_DN;
          count_d = POWER_DOWN_CYCLES;
        end
      end
      CH_RAMP_DN: begin
        count_d = count_q - 8'h01;
        if (count_done) begin
          state_d = CH_OFF;
        end
      end
    endcase
  end

  // state, counter and registered outputs
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      state_q   <= CH_OFF;
      count_q   <= COUNT_RESET;
      supply_on <= 1'b0;
      powered   <= 1'b0;
    end else begin
      state_q   <= state_d;
      count_q   <= count_d;
      supply_on <= (state_d == CH_RAMP_UP) | (state_d == CH_ON);
      powered   <= (state_d == CH_ON);
    end
  end

endmodule : chan_power_seq

//--- rtl/channel_power_control.sv
`timescale 1ns/100ps
// Functional notes
// - four channel enables, one and two on
// - global bit off powers all channels down
// - bit five switches microphone bias supply
// - bit three enables ultrasound activity detection
// - bit two enables voice activity detection
// - without dynamic mode and with the global bit on, no change while recording
// - range bit picks channels one-two or one-four
// - bit three flags separate modulator and density clocks
// - status bits seven to four show power
module channel_power_control (
  input  wire logic       sys_clk,
  input  wire logic       rst,
  input  wire logic [7:0] reg_addr,
  input  wire logic [7:0] reg_wdata,
  input  wire logic       reg_wr,
  input  wire logic       reg_rd,
  output logic      [7:0] reg_rdata,
  output logic            reg_rvalid,
  output logic      [3:0] chan_supply_on,
  output logic      [3:0] chan_powered,
  output logic            mic_supply_on,
  output logic            ultrasound_detect_on,
  output logic            voice_detect_on,
  output logic            separate_clock_on,
  output logic            recording
);
  import chan_power_pkg::*;

  // ----------------------------------------------------------------
  // register storage
  // ----------------------------------------------------------------
  logic [7:0] channel_enable_q;
  logic [7:0] dynamic_power_config_q;
  logic [7:0] power_control_q;
  logic [7:0] channel_enable_d;
  logic [7:0] dynamic_power_config_d;
  logic [7:0] power_control_d;
  logic [7:0] rdata_d;

  logic       wr_chan_en;
  logic       wr_dyn_cfg;
  logic       wr_pwr;
  logic       hit_chan_en;
  logic       hit_dyn_cfg;
  logic       hit_pwr;
  logic       hit_status;
  logic [7:0] status_view;

  // ----------------------------------------------------------------
  // address decode
  // ----------------------------------------------------------------
  assign hit_chan_en = (reg_addr == CHANNEL_ENABLE_ADDR);
  assign hit_dyn_cfg = (reg_addr == DYNAMIC_POWER_CONFIG_ADDR);
  assign hit_pwr     = (reg_addr == POWER_CONTROL_ADDR);
  assign hit_status  = (reg_addr == CHANNEL_POWER_STATUS_ADDR);
  assign wr_chan_en  = reg_wr & hit_chan_en;
  assign wr_dyn_cfg  = reg_wr & hit_dyn_cfg;
  assign wr_pwr      = reg_wr & hit_pwr;

  // write merge: read-only bits keep their stored value
  assign channel_enable_d = wr_chan_en ?
      ((reg_wdata & CHANNEL_ENABLE_WMASK) | (channel_enable_q & ~CHANNEL_ENABLE_WMASK)) :
      channel_enable_q;
  assign dynamic_power_config_d = wr_dyn_cfg ?
      ((reg_wdata & DYNAMIC_POWER_CONFIG_WMASK) |
       (dynamic_power_config_q & ~DYNAMIC_POWER_CONFIG_WMASK)) :
      dynamic_power_config_q;
  assign power_control_d = wr_pwr ?
      ((reg_wdata & POWER_CONTROL_WMASK) | (power_control_q & ~POWER_CONTROL_WMASK)) :
      power_control_q;

  // read mux; status shows channel one in bit 7, lower nibble reads zero
  assign status_view = {chan_powered[0], chan_powered[1], chan_powered[2], chan_powered[3],
                        4'h0};
  assign rdata_d = hit_chan_en ? channel_enable_q :
                   hit_dyn_cfg ? dynamic_power_config_q :
                   hit_pwr     ? power_control_q :
                   hit_status  ? status_view :
                   8'h00;

  // ----------------------------------------------------------------
  // register process
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      channel_enable_q       <= CHANNEL_ENABLE_RESET;
      dynamic_power_config_q <= DYNAMIC_POWER_CONFIG_RESET;
      power_control_q        <= POWER_CONTROL_RESET;
      reg_rdata              <= CHANNEL_POWER_STATUS_RESET;
      reg_rvalid             <= 1'b0;
    end else begin
      channel_enable_q       <= channel_enable_d;
      dynamic_power_config_q <= dynamic_power_config_d;
      power_control_q        <= power_control_d;
      reg_rdata              <= reg_rd ? rdata_d : reg_rdata;
      reg_rvalid             <= reg_rd;
    end
  end

  // ----------------------------------------------------------------
  // control fields
  // ----------------------------------------------------------------
  logic [3:0] input_enable;
  logic       converter_global_power;
  logic       dynamic_power_switch_enable;
  logic       dynamic_channel_range_select;
  logic [3:0] dynamic_member;
  logic [3:0] target_on;
  logic [3:0] allow_change;

  // channel one sits in bit 7, so index 0 maps to channel one
  assign input_enable = {channel_enable_q[INPUT_ENABLE_LSB],
                         channel_enable_q[INPUT_ENABLE_LSB+1],
                         channel_enable_q[INPUT_ENABLE_LSB+2],
                         channel_enable_q[INPUT_ENABLE_LSB+3]};
  assign converter_global_power       = power_control_q[CONVERTER_GLOBAL_BIT];
  assign dynamic_power_switch_enable  = dynamic_power_config_q[DYNAMIC_SWITCH_BIT];
  assign dynamic_channel_range_select = dynamic_power_config_q[DYNAMIC_RANGE_BIT];

  // target: enabled channels only while the global bit is set
  assign target_on = input_enable & {4{converter_global_power}};

  // channels that may switch individually while others record
  assign dynamic_member = {{2{dynamic_power_switch_enable & dynamic_channel_range_select}},
                           {2{dynamic_power_switch_enable}}};

  // any channel fully up counts as recording
  assign recording = |chan_powered;

  // a global power-down is always honoured; otherwise changes wait for idle unless the channel is a dynamic member
  assign allow_change = dynamic_member | {4{~recording}} |
                        {4{~converter_global_power}};

  // ----------------------------------------------------------------
  // per-channel power sequencers
  // ----------------------------------------------------------------
  generate
    for (genvar ch = 0; ch < 4; ch++) begin : g_chan
      chan_power_seq u_seq (
        .sys_clk      (sys_clk),
        .rst          (rst),
        .target_on    (target_on[ch]),
        .allow_change (allow_change[ch]),
        .supply_on    (chan_supply_on[ch]),
        .powered      (chan_powered[ch])
      );
    end
  endgenerate

  // ----------------------------------------------------------------
  // side controls, registered
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      mic_supply_on        <= 1'b0;
      ultrasound_detect_on <= 1'b0;
      voice_detect_on      <= 1'b0;
      separate_clock_on    <= 1'b0;
    end else begin
      mic_supply_on        <= power_control_d[MIC_SUPPLY_BIT];
      ultrasound_detect_on <= power_control_d[ULTRASOUND_DETECT_BIT];
      voice_detect_on      <= power_control_d[VOICE_DETECT_BIT];
      separate_clock_on    <= dynamic_power_config_d[DYNAMIC_SEP_CLOCK_BIT];
    end
  end

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  localparam int DOWN_BOUND = 24;
  localparam int UP_HOLD    = 8;

  // ----------------------------------------------------------------
  // assertion helper
  // ----------------------------------------------------------------
  logic [7:0] up_run_q;

  // cycles channel one has had supply without being powered
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      up_run_q <= COUNT_RESET;
    end else if (chan_supply_on[0] && !chan_powered[0]) begin
      up_run_q <= up_run_q + 8'h01;
    end else begin
      up_run_q <= COUNT_RESET;
    end
  end

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);

  sequence s_global_drop;
    $fell(converter_global_power) ##1 !converter_global_power;
  endsequence

  sequence s_hold_no_dyn;
    (!dynamic_power_switch_enable && converter_global_power);
  endsequence

  sequence s_static_recording;
    (recording && !dynamic_power_switch_enable && converter_global_power);
  endsequence

  sequence s_narrow_recording;
    (recording && dynamic_power_switch_enable && !dynamic_channel_range_select &&
     converter_global_power);
  endsequence

  a_enable_write: assert property (
    wr_chan_en |=> (input_enable[0] == $past(reg_wdata[7])) &&
                   (input_enable[3] == $past(reg_wdata[4])))
    else $error("channel enable write not stored");

  a_global_down: assert property (
    s_global_drop |-> ##[0:DOWN_BOUND] (chan_powered == 4'h0))
    else $error("channels stay powered after global power off");

  a_bias_write: assert property (
    wr_pwr |=> (mic_supply_on == $past(reg_wdata[5])))
    else $error("mic supply does not follow write");

  a_ultra_write: assert property (
    wr_pwr |=> (ultrasound_detect_on == $past(reg_wdata[3])))
    else $error("ultrasound detect does not follow write");

  a_voice_write: assert property (
    wr_pwr |=> (voice_detect_on == $past(reg_wdata[2])))
    else $error("voice detect does not follow write");

  a_hold_static: assert property (
    s_hold_no_dyn |=> (($past(chan_powered) & ~chan_powered) == 4'h0))
    else $error("channel powered down while recording without dynamic mode");

  a_range_upper: assert property (
    (converter_global_power && !dynamic_channel_range_select) |=>
      (($past(chan_powered[3:2]) & ~chan_powered[3:2]) == 2'b00))
    else $error("upper channel switched outside the dynamic range");

  a_sep_clock: assert property (
    wr_dyn_cfg |=> (separate_clock_on == $past(reg_wdata[3])))
    else $error("separate clock flag does not follow write");

  a_status_read: assert property (
    (reg_rd && hit_status) |=> reg_rvalid && (reg_rdata[3:0] == 4'h0) &&
      (reg_rdata[7] == $past(chan_powered[0])) && (reg_rdata[6] == $past(chan_powered[1])) &&
      (reg_rdata[5] == $past(chan_powered[2])) && (reg_rdata[4] == $past(chan_powered[3])))
    else $error("status read does not show channel power");

  a_powered_cause: assert property (
    $rose(chan_powered[0]) |-> $past(target_on[0], 1) && $past(chan_supply_on[0], UP_HOLD))
    else $error("channel one powered without enable, global bit and ramp");

  a_static_no_start: assert property (
    s_static_recording |=> ((chan_supply_on & ~$past(chan_supply_on)) == 4'h0))
    else $error("channel powered up while recording without dynamic mode");

  a_narrow_upper_hold: assert property (
    s_narrow_recording |=> ((chan_supply_on[3:2] & ~$past(chan_supply_on[3:2])) == 2'b00))
    else $error("upper channel powered up outside the dynamic range");

  a_global_no_start: assert property (
    !converter_global_power |=> ((chan_supply_on & ~$past(chan_supply_on)) == 4'h0))
    else $error("channel ramp started with global power off");

  a_global_all_down: assert property (
    !converter_global_power |=> (($past(chan_powered) & chan_powered) == 4'h0))
    else $error("powered channel kept up with global power off");

  a_down_ramp_off: assert property (
    $fell(chan_powered[0]) |-> (!chan_supply_on[0]) [*8])
    else $error("channel one supply back on during power-down");

  a_up_ramp_len: assert property (
    $rose(chan_powered[0]) |-> (up_run_q == POWER_UP_CYCLES))
    else $error("channel one powered before its ramp completed");

  a_supply_under_power: assert property (
    (chan_powered & ~chan_supply_on) == 4'h0)
    else $error("channel powered without its supply");

  a_enable_middle: assert property (
    wr_chan_en |=> (input_enable[1] == $past(reg_wdata[6])) &&
                   (input_enable[2] == $past(reg_wdata[5])))
    else $error("channel two or three enable write not stored");

  a_read_valid: assert property (
    reg_rd |=> reg_rvalid)
    else $error("read not answered in the next cycle");

  a_read_quiet: assert property (
    !reg_rd |=> !reg_rvalid && $stable(reg_rdata))
    else $error("read data changed without a read");

  a_sep_hold: assert property (
    !wr_dyn_cfg |=> $stable(separate_clock_on))
    else $error("separate clock flag changed without a write");

endmodule : channel_power_control

//--- bench/tb.sv
`timescale 1ns/100ps
module tb;
  import chan_power_pkg::*;

  // ----------------------------------------------------------------
  // clock, reset and design stimulus
  // ----------------------------------------------------------------
  logic       sys_clk     = 1'b0;
  logic       rst         = 1'b1;
  logic [7:0] reg_addr    = 8'h00;
  logic [7:0] reg_wdata   = 8'h00;
  logic       reg_wr      = 1'b0;
  logic       reg_rd      = 1'b0;
  logic [7:0] reg_rdata;
  logic       reg_rvalid;
  logic [3:0] chan_supply_on;
  logic [3:0] chan_powered;
  logic       mic_supply_on;
  logic       ultrasound_detect_on;
  logic       voice_detect_on;
  logic       separate_clock_on;
  logic       recording;
  int         failures     = 0;
  int         total_checks = 0;

  // 40 MHz clock
  always #12.5 sys_clk = ~sys_clk;

  channel_power_control DUT (
    .sys_clk              (sys_clk),
    .rst                  (rst),
    .reg_addr             (reg_addr),
    .reg_wdata            (reg_wdata),
    .reg_wr               (reg_wr),
    .reg_rd               (reg_rd),
    .reg_rdata            (reg_rdata),
    .reg_rvalid           (reg_rvalid),
    .chan_supply_on       (chan_supply_on),
    .chan_powered         (chan_powered),
    .mic_supply_on        (mic_supply_on),
    .ultrasound_detect_on (ultrasound_detect_on),
    .voice_detect_on      (voice_detect_on),
    .separate_clock_on    (separate_clock_on),
    .recording            (recording)
  );

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  // compare one value and count it
  task automatic chk(input logic [7:0] seen, input logic [7:0] expd);
    total_checks++;
    if (seen !== expd) begin
      failures++;
      $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, expd);
    end
  endtask : chk

  // wait n edges, then let updates settle
  task automatic cyc(input int n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask : cyc

  // one-cycle write strobe
  task automatic wr(input logic [7:0] addr, input logic [7:0] data);
    @(posedge sys_clk);
    reg_addr  <= addr;
    reg_wdata <= data;
    reg_wr    <= 1'b1;
    @(posedge sys_clk);
    reg_wr    <= 1'b0;
  endtask : wr

  // one-cycle read strobe, data checked in the valid cycle
  task automatic rd(input logic [7:0] addr, input logic [7:0] expd);
    @(posedge sys_clk);
    reg_addr <= addr;
    reg_rd   <= 1'b1;
    @(posedge sys_clk);
    reg_rd   <= 1'b0;
    #1;
    chk({7'h00, reg_rvalid}, 8'h01);
    chk(reg_rdata, expd);
  endtask : rd

  // channel outputs: supply and powered, channel one in bit 0
  task automatic chan(input logic [3:0] sup, input logic [3:0] pwr);
    chk({4'h0, chan_supply_on}, {4'h0, sup});
    chk({4'h0, chan_powered}, {4'h0, pwr});
    chk({7'h00, recording}, {7'h00, |pwr});
  endtask : chan

  // verdict and end of run
  task automatic end_sim;
    $display("checks %0d failures %0d", total_checks, failures);
    if (failures == 0 && total_checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : end_sim

  // ----------------------------------------------------------------
  // tests
  // ----------------------------------------------------------------
  initial begin
    repeat (16) @(posedge sys_clk);
    rst <= 1'b0;
    // reset values
    rd(CHANNEL_ENABLE_ADDR, 8'hcc);
    rd(DYNAMIC_POWER_CONFIG_ADDR, 8'h00);
    rd(POWER_CONTROL_ADDR, 8'h00);
    rd(CHANNEL_POWER_STATUS_ADDR, 8'h00);
    chan(4'h0, 4'h0);
    // writable masks and side outputs, global bit left off
    wr(POWER_CONTROL_ADDR, 8'h7f);
    rd(POWER_CONTROL_ADDR, 8'h6e);
    chk({5'h00, mic_supply_on, ultrasound_detect_on, voice_detect_on}, 8'h07);
    chan(4'h0, 4'h0);
    wr(DYNAMIC_POWER_CONFIG_ADDR, 8'h3f);
    rd(DYNAMIC_POWER_CONFIG_ADDR, 8'h38);
    chk({7'h00, separate_clock_on}, 8'h01);
    wr(POWER_CONTROL_ADDR, 8'h08);
    cyc(2);
    chk({5'h00, mic_supply_on, ultrasound_detect_on, voice_detect_on}, 8'h02);
    wr(POWER_CONTROL_ADDR, 8'h04);
    cyc(2);
    chk({5'h00, mic_supply_on, ultrasound_detect_on, voice_detect_on}, 8'h01);
    wr(DYNAMIC_POWER_CONFIG_ADDR, 8'h00);
    cyc(2);
    chk({7'h00, separate_clock_on}, 8'h00);
    // read-only status and an unmapped place
    wr(CHANNEL_POWER_STATUS_ADDR, 8'hff);
    rd(CHANNEL_POWER_STATUS_ADDR, 8'h00);
    wr(8'h7a, 8'hff);
    rd(8'h7a, 8'h00);
    // global power up: channels one and two ramp
    wr(POWER_CONTROL_ADDR, 8'h80);
    cyc(3);
    chk({5'h00, mic_supply_on, ultrasound_detect_on, voice_detect_on}, 8'h00);
    chan(4'h3, 4'h0);
    cyc(20);
    chan(4'h3, 4'h0);
    cyc(25);
    chan(4'h3, 4'h3);
    rd(CHANNEL_POWER_STATUS_ADDR, 8'hc0);
    // static mode: enabling channel three while recording is held off
    wr(CHANNEL_ENABLE_ADDR, 8'hec);
    cyc(50);
    chan(4'h3, 4'h3);
    // global off overrides the hold
    wr(POWER_CONTROL_ADDR, 8'h00);
    cyc(3);
    chan(4'h0, 4'h0);
    cyc(25);
    wr(POWER_CONTROL_ADDR, 8'h80);
    cyc(46);
    chan(4'h7, 4'h7);
    rd(CHANNEL_POWER_STATUS_ADDR, 8'he0);
    // dynamic mode limited to channels one and two
    wr(DYNAMIC_POWER_CONFIG_ADDR, 8'h80);
    wr(CHANNEL_ENABLE_ADDR, 8'hbc);
    cyc(3);
    chk({4'h0, chan_powered}, 8'h05);
    cyc(50);
    chan(4'h5, 4'h5);
    // full range lets channel four follow its enable
    wr(DYNAMIC_POWER_CONFIG_ADDR, 8'hc0);
    cyc(46);
    chan(4'hd, 4'hd);
    rd(CHANNEL_POWER_STATUS_ADDR, 8'hb0);
    end_sim();
  end

  // watchdog, far beyond the few hundred cycles the tests need
  initial begin
    repeat (5000) @(posedge sys_clk);
    failures++;
    end_sim();
  end

endmodule : tb
